// File: pot_regmap_pkg.sv
/*
  pot_regmap_pkg: offsets, field positions and reset values for the
  volatile register map of the potentiometer control block.
  assumes a 32-bit classic wishbone register bus with byte addressing.
*/
package pot_regmap_pkg;

  // printed location indices; byte address is four times the index
  localparam logic [3:0] idx_wiper0 = 4'h0;
  localparam logic [3:0] idx_wiper1 = 4'h1;
  localparam logic [3:0] idx_term_ctrl = 4'h4;
  localparam logic [3:0] idx_fixed = 4'h5;
  // own control/status registers above the 16-location map
  localparam logic [4:0] idx_supply_ctrl = 5'h10;
  localparam logic [4:0] idx_supply_stat = 5'h11;

  localparam int data_width = 9;
  localparam logic [8:0] wiper_mid_scale = 9'h080;
  localparam logic [8:0] term_ctrl_reset = 9'h1ff;
  localparam logic [8:0] fixed_value = 9'h1f7;

  // terminal control field positions
  localparam int pos_net0_term_b = 0;
  localparam int pos_net0_wiper = 1;
  localparam int pos_net0_term_a = 2;
  localparam int pos_net0_hw = 3;
  localparam int pos_net1_term_b = 4;
  localparam int pos_net1_wiper = 5;
  localparam int pos_net1_term_a = 6;
  localparam int pos_net1_hw = 7;
  localparam int pos_gc_en = 8;

  // supply control register fields
  localparam int pos_supply_ok = 0;
  localparam int pos_net0_lock = 1;
  localparam int pos_net1_lock = 2;
  localparam logic [2:0] supply_ctrl_reset = 3'h0;

  // supply status register fields
  localparam int pos_stat_ready = 0;
  localparam int pos_stat_reset_seen = 1;
  localparam int pos_stat_corrupt = 2;

endpackage

// File: pot_volatile_regmap_por.sv
/*
  pot_volatile_regmap_por: volatile register map of a digital
  potentiometer, with power-on and brown-out reset behaviour modelled
  by a software-controlled supply-good level, and terminal outputs.
  assumes a classic wishbone master, one clock, synchronous reset.
*/
// Design decision made here: the Wishbone slave port.
// What this block does
// - decode sixteen locations of nine bits
// - wiper0 at 00h, wiper1 01h, terminal 04h
// - second wiper exists only in dual variant
// - location 05h always reads 1f7h; here it reads 0 while supply-good is low
// - power-on loads wipers with mid-scale
// - every supply reset loads terminal control 1ffh
// - above trip point, serial commands accepted
// - below trip point, serial interface disabled
// - low supply still allows volatile operations; here the map is closed whenever supply-good is low
// - interrupted command may leave location corrupt
// - terminal register nine bits, all rw, reset one
// - bit 8 gates general call response
// - separate connect control per terminal
// - new terminal value applied after write completes
// - net1 lock blocks net1 terminal writes
// - net0 lock blocks net0 terminal writes
// - general call accepted only when bit one
// - shutdown bit zero forces network shutdown
// - connect bit one connects terminal
module pot_volatile_regmap_por
  import pot_regmap_pkg::*;
#(
  parameter bit dual_network = 1'b1
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic general_call_accept_en,
  output logic net0_hw_shutdown_n,
  output logic net0_term_a_connect,
  output logic net0_wiper_connect,
  output logic net0_term_b_connect,
  output logic net1_hw_shutdown_n,
  output logic net1_term_a_connect,
  output logic net1_wiper_connect,
  output logic net1_term_b_connect,
  output logic [8:0] wiper0_out,
  output logic [8:0] wiper1_out
);

  typedef enum logic [1:0]
  {
    st_off = 2'b01,
    st_run = 2'b10
  } supply_type;

  supply_type supply_reg;
  supply_type supply_next;
  logic [8:0] wiper0_position_reg;
  logic [8:0] wiper1_position_reg;
  logic [8:0] term_ctrl_reg;
  logic [8:0] term_applied_reg;
  logic [2:0] supply_ctrl_reg;
  logic reset_seen_reg;
  logic corrupt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic req;
  logic wr_fire;
  logic wb_wr;
  logic [4:0] word_idx;
  logic low_ok;
  logic high_ok;
  logic in_map;
  logic map_ok;
  logic supply_ok;
  logic power_up;
  logic brown_out;
  logic [8:0] wdata9;
  logic [8:0] term_ctrl_next;

  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign word_idx = wb_adr_i[6:2];
  assign in_map = (word_idx[4] == 1'b0);
  assign low_ok = wb_sel_i[0];
  assign high_ok = wb_sel_i[1];
  assign wb_wr = req & wb_we_i;
  assign wdata9 = wb_dat_i[8:0];
  assign supply_ok = supply_ctrl_reg[pos_supply_ok];
  // map is unreachable while the supply is below trip point
  assign map_ok = in_map & (supply_reg == st_run);
  // only while running do map writes land
  assign wr_fire = wb_wr & map_ok & low_ok & high_ok;
  assign power_up = (supply_reg == st_off) & supply_ok;
  assign brown_out = (supply_reg == st_run) & ~supply_ok;

  always_comb
  begin
    supply_next = supply_reg;
    unique case (supply_reg)
      st_off:
      begin
        if (supply_ok)
          supply_next = st_run;
      end
      st_run:
      begin
        if (!supply_ok)
          supply_next = st_off;
      end
      default:
        supply_next = st_off;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      supply_reg <= st_off;
    else
      supply_reg <= supply_next;
  end

  // the supply-good level alone gates access, no voltage band
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      supply_ctrl_reg <= supply_ctrl_reset;
    else if (wb_wr && word_idx == idx_supply_ctrl && low_ok)
      supply_ctrl_reg <= wb_dat_i[2:0];
  end

  // wipers, mid-scale on each rise through the trip point
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      wiper0_position_reg <= wiper_mid_scale;
      wiper1_position_reg <= wiper_mid_scale;
    end
    else if (power_up)
    begin
      wiper0_position_reg <= wiper_mid_scale;
      wiper1_position_reg <= wiper_mid_scale;
    end
    // decode of the two wiper locations
    else if (wr_fire && word_idx[3:0] == idx_wiper0)
      wiper0_position_reg <= wdata9;
    // second wiper writable only in the dual build
    else if (wr_fire && word_idx[3:0] == idx_wiper1 && dual_network)
      wiper1_position_reg <= wdata9;
  end

  // net1 field kept while its lock is set
  // net0 field kept while its lock is set
  always_comb
  begin
    term_ctrl_next = term_ctrl_reg;
    term_ctrl_next[pos_gc_en] = wdata9[pos_gc_en];
    if (!supply_ctrl_reg[pos_net0_lock])
      term_ctrl_next[3:0] = wdata9[3:0];
    if (!supply_ctrl_reg[pos_net1_lock])
      term_ctrl_next[7:4] = wdata9[7:4];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      term_ctrl_reg <= term_ctrl_reset;
    // every supply reset reloads all ones
    else if (power_up)
      term_ctrl_reg <= term_ctrl_reset;
    else if (wr_fire && word_idx[3:0] == idx_term_ctrl)
      term_ctrl_reg <= term_ctrl_next;
  end

  // terminals follow the register one cycle later, on the edge where the write ends
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      term_applied_reg <= term_ctrl_reset;
    else
      term_applied_reg <= term_ctrl_reg;
  end

  // flag stays until software reads status, so host can detect
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      reset_seen_reg <= 1'b1;
    else if (power_up)
      reset_seen_reg <= 1'b1;
    else if (req && !wb_we_i && word_idx == idx_supply_stat)
      reset_seen_reg <= 1'b0;
  end

  // a map request cut by brown-out is flagged, contents not restored
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      corrupt_reg <= 1'b0;
    else if (brown_out && wb_cyc_i && wb_stb_i && in_map)
      corrupt_reg <= 1'b1;
    else if (wb_wr && word_idx == idx_supply_stat && low_ok)
      corrupt_reg <= 1'b0;
  end

  // sixteen nine-bit locations, upper bits read zero
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (map_ok)
    begin
      unique case (word_idx[3:0])
        idx_wiper0:
          rdata_next[8:0] = wiper0_position_reg;
        idx_wiper1:
          rdata_next[8:0] = dual_network ? wiper1_position_reg : 9'h000;
        idx_term_ctrl:
          rdata_next[8:0] = term_ctrl_reg;
        idx_fixed:
          rdata_next[8:0] = fixed_value;
        default:
          rdata_next = 32'h0000_0000;
      endcase
    end
    else if (word_idx == idx_supply_ctrl)
      rdata_next[2:0] = supply_ctrl_reg;
    else if (word_idx == idx_supply_stat)
    begin
      rdata_next[pos_stat_ready] = (supply_reg == st_run);
      rdata_next[pos_stat_reset_seen] = reset_seen_reg;
      rdata_next[pos_stat_corrupt] = corrupt_reg;
    end
  end

  // one wait state; every address, mapped or not, is acked
  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ack_reg <= req;
      if (req && !wb_we_i)
        rdata_reg <= rdata_next;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  assign general_call_accept_en = term_applied_reg[pos_gc_en];
  assign net0_hw_shutdown_n = term_applied_reg[pos_net0_hw];
  assign net1_hw_shutdown_n = term_applied_reg[pos_net1_hw];
  assign net0_term_a_connect = term_applied_reg[pos_net0_term_a];
  assign net0_wiper_connect = term_applied_reg[pos_net0_wiper];
  assign net0_term_b_connect = term_applied_reg[pos_net0_term_b];
  assign net1_term_a_connect = term_applied_reg[pos_net1_term_a];
  assign net1_wiper_connect = term_applied_reg[pos_net1_wiper];
  assign net1_term_b_connect = term_applied_reg[pos_net1_term_b];
  assign wiper0_out = wiper0_position_reg;
  assign wiper1_out = dual_network ? wiper1_position_reg : 9'h000;

endmodule

// File: pot_volatile_regmap_por_asserts.sv
/*
  pot_regmap_checker: bus and terminal assertions on the register map.
  assumes one clock and a synchronous active-low reset.
*/
module pot_regmap_checker (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic general_call_accept_en,
  input wire logic net0_hw_shutdown_n,
  input wire logic net0_term_a_connect,
  input wire logic net0_wiper_connect,
  input wire logic net0_term_b_connect,
  input wire logic net1_hw_shutdown_n,
  input wire logic net1_term_a_connect,
  input wire logic net1_wiper_connect,
  input wire logic net1_term_b_connect,
  input wire logic [8:0] wiper0_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire logic [8:0] term = {general_call_accept_en, net1_hw_shutdown_n,
    net1_term_a_connect, net1_wiper_connect, net1_term_b_connect,
    net0_hw_shutdown_n, net0_term_a_connect, net0_wiper_connect,
    net0_term_b_connect};
  wire logic taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
  ack_after_req_a: assert property (taken |=> wb_ack_o)
    else $error("request not acked next cycle");
  ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_idle_low_a: assert property (!wb_stb_i |=> !wb_ack_o)
    else $error("ack without a request");
  upper_bits_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:9] == 0)
    else $error("read data above bit 8 not zero");
  reserved_read_zero_a: assert property (taken && !wb_we_i &&
    wb_adr_i[6:2] inside {5'h2, 5'h3, [5'h6:5'hf], [5'h12:5'h1f]}
    |=> wb_dat_o == 0) else $error("reserved read not zero");
  reset_term_ones_a: assert property ($rose(resetn) |-> term == 9'h1ff)
    else $error("terminals not all set after reset");
  reset_wiper_mid_a: assert property ($rose(resetn) |-> wiper0_out == 9'h080)
    else $error("wiper not mid-scale after reset");
  term_idle_hold_a: assert property (!wb_cyc_i [*4] |=> $stable({term,
    wiper0_out})) else $error("outputs moved with no bus traffic");
  read_data_hold_a: assert property ($changed(wb_dat_o) |->
    $past(taken && !wb_we_i)) else $error("read data moved without a read");
  cover property (taken && wb_we_i);
  cover property (taken && !wb_we_i);
  cover property ($changed(general_call_accept_en));
endmodule

bind pot_volatile_regmap_por pot_regmap_checker u_chk (.clk_sys, .resetn,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o,
  .general_call_accept_en, .net0_hw_shutdown_n, .net0_term_a_connect,
  .net0_wiper_connect, .net0_term_b_connect, .net1_hw_shutdown_n,
  .net1_term_a_connect, .net1_wiper_connect, .net1_term_b_connect,
  .wiper0_out);

// File: host_bus_model.sv
/*
  host_bus_model: classic wishbone host on the far side of the block.
  assumes the slave acks each request within 50 cycles.
*/
module host_bus_model (
  input wire logic clk_sys,
  input wire logic ack,
  input wire logic [31:0] rdat,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [31:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat,
  output logic hang
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    {cyc, stb, we, adr, sel, wdat, hang} = '0;
  end
  // request held until ack is sampled high
  task automatic xfer(input logic w, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50)
      hang <= 1'b1;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk_sys);
  endtask
endmodule

// File: pot_volatile_regmap_por_tb_top.sv
/*
  bench for the register map: bus sequences with expected values.
  assumes the host model above and the package constants.
*/
module pot_volatile_regmap_por_tb_top
  import pot_regmap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic cyc, stb, we, ack, hang;
  logic [31:0] adr, wdat, rdat;
  logic [3:0] sel;
  logic [8:0] term, w0, w1;
  int failures = 0;
  int samples_checked = 0;
  always #20 clk_sys = ~clk_sys;
  host_bus_model host (.clk_sys(clk_sys), .ack(ack), .rdat(rdat),
    .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat),
    .hang(hang));
  pot_volatile_regmap_por dut (.clk_sys(clk_sys), .resetn(resetn),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .general_call_accept_en(term[8]), .net1_hw_shutdown_n(term[7]),
    .net1_term_a_connect(term[6]), .net1_wiper_connect(term[5]),
    .net1_term_b_connect(term[4]), .net0_hw_shutdown_n(term[3]),
    .net0_term_a_connect(term[2]), .net0_wiper_connect(term[1]),
    .net0_term_b_connect(term[0]), .wiper0_out(w0), .wiper1_out(w1));
  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e,
    input string nm);
    logic [31:0] q;
    host.xfer(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic end_sim();
    if (failures == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // a hung bus counts against the run
  always @(posedge hang)
  begin
    failures++;
    end_sim();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    wr(32'h0, 32'h1c3);
    rdc(32'h0, 32'h0, "wiper0_off");
    wr(32'h40, 32'h1);
    rdc(32'h0, {23'h0, wiper_mid_scale}, "wiper0_up");
    rdc(32'h4, {23'h0, wiper_mid_scale}, "wiper1_up");
    rdc(32'h10, {23'h0, term_ctrl_reset}, "term_ctrl_up");
    rdc(32'h14, {23'h0, fixed_value}, "fixed");
    for (int i = 2; i < 16; i++)
      if (i != 4 && i != 5)
      begin
        wr(32'(i * 4), 32'h1a5);
        rdc(32'(i * 4), 32'h0, "reserved");
      end
    rdc(32'h60, 32'h0, "unmapped");
    rdc(32'h0, {23'h0, wiper_mid_scale}, "wiper0_kept");
    wr(32'h0, 32'h1c3);
    rdc(32'h0, 32'h1c3, "wiper0");
    chk("wiper0_out", {23'h0, w0}, 32'h1c3);
    wr(32'h4, 32'h055);
    chk("wiper1_out", {23'h0, w1}, 32'h055);
    // every terminal bit driven both ways
    for (int k = 0; k < 2; k++)
    begin
      wr(32'h10, k ? 32'h15a : 32'h0a5);
      chk("terminals", {23'h0, term}, k ? 32'h15a : 32'h0a5);
    end
    wr(32'h40, 32'h3);
    wr(32'h10, 32'h0);
    rdc(32'h10, 32'h00a, "term_lock0");
    wr(32'h40, 32'h5);
    wr(32'h10, 32'h1ff);
    rdc(32'h10, 32'h10f, "term_lock1");
    // brown-out then recovery reloads defaults
    wr(32'h40, 32'h0);
    rdc(32'h10, 32'h0, "term_ctrl_off");
    wr(32'h40, 32'h1);
    rdc(32'h10, {23'h0, term_ctrl_reset}, "term_ctrl_bor");
    rdc(32'h0, {23'h0, wiper_mid_scale}, "wiper0_bor");
    wr(32'h10, 32'h0f0);
    rdc(32'h10, 32'h0f0, "term_ctrl_restore");
    rdc(32'h44, 32'h3, "reset_seen_set");
    rdc(32'h44, 32'h1, "reset_seen_clear");
    end_sim();
  end
endmodule
